// ---- scvc_top.sv ----
// scvc_top: spindle commutation, brake delay, back-emf timing and actuator dac control
// Notes on behaviour
// - park or brake start waits 128 falling phase-a crossings before braking
// - brake counter state readable: braking start, park start and park end
// - chip select frames accesses; dropping it resets the port state
// - thermal shutdown disables the port: reads all ones, writes ignored
// - current-limit comparator exposed as a status bit
// - current-limit bit sticky until status read clears it
// - each step clock rising edge advances the bipolar sequence one step
// - counter steps on step clock; reset from preload acts immediately
// - host writes preload; high-side bit beats low-side bit
// - preload one turns that driver on
// - preload not all ones holds counter reset, preload drives pattern
// - all-ones preload frees counter and selects counter pattern
// - all-zero preload tristates drivers and resets counter
// - latch takes previous counter state or preload on each step edge
// - sample/hold tracks in pwm on-time, holds in off-time and on-delay
// - startup uses crossings of all phases, run uses phase a only
// - zero-cross pin high impedance while reset active
// - prequalifier versus on-delay comparison readable in status
// - actuator dac takes a 10-bit code
// - three attenuator bits, any combination enabled together
// - saturated seek drives polarity from dac sign; status from own comparator
// - outside braking and shutdown, spindle drive pattern changes only on a step clock edge
// - thermal warning flag present in every register read
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module scvc_top #(
  parameter int BRAKE_CROSSINGS = scvc_pkg::BRAKE_COUNT
) (
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_resetn,
  input  wire logic [scvc_pkg::ADDR_W-1:0] i_avs_address,
  input  wire logic                        i_avs_chipselect,
  input  wire logic                        i_avs_read,
  input  wire logic                        i_avs_write,
  input  wire logic [scvc_pkg::DATA_W-1:0] i_avs_writedata,
  input  wire logic [3:0]                  i_avs_byteenable,
  output logic      [scvc_pkg::DATA_W-1:0] o_avs_readdata,
  output logic                             o_avs_waitrequest,
  input  wire logic                        i_spindle_step_clock,
  input  wire logic                        i_zc_phase_a,
  input  wire logic                        i_zc_phase_b,
  input  wire logic                        i_zc_phase_c,
  input  wire logic                        i_pwm_in,
  input  wire logic                        i_on_delay,
  input  wire logic                        i_prequal_cmp,
  input  wire logic                        i_cur_limit_cmp,
  input  wire logic                        i_sat_detect_cmp,
  input  wire logic                        i_thermal_warn,
  input  wire logic                        i_thermal_shutdown,
  output logic      [2:0]                  o_drive_hi,
  output logic      [2:0]                  o_drive_lo,
  output logic                             o_drive_oe,
  output logic                             o_sample_hold_pin,
  output logic                             o_zero_cross,
  output logic                             o_zero_cross_oe,
  output logic                             o_park,
  output logic      [9:0]                  o_actuator_dac,
  output logic      [2:0]                  o_atten_sel,
  output logic                             o_sat_seek,
  output logic                             o_sat_polarity
);
  import scvc_pkg::*;

  // ==========================================================================
  // parameter check
  // eight-bit brake counter; a count of zero is rejected
  if (BRAKE_CROSSINGS < 1 || BRAKE_CROSSINGS > 255) begin : g_bad_crossings
    $error("BRAKE_CROSSINGS must lie in 1..255");
  end

  localparam logic [7:0] BRAKE_END  = 8'(BRAKE_CROSSINGS);
  localparam logic [7:0] BRAKE_LAST = 8'(BRAKE_CROSSINGS - 1);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [1:0]       step_s;
    logic             step_d;
    logic [2:0]       zc_s1;
    logic [2:0]       zc_s2;
    logic [2:0]       zc_d;
    logic [MI_W-1:0]  mi_s1;
    logic [MI_W-1:0]  mi_s2;
    logic             wait_req;
    logic [31:0]      rdata;
    logic [CTRL_W-1:0] ctrl;
    logic [PRE_W-1:0] preload;
    logic [DAC_W-1:0] dac;
    logic [ATT_W-1:0] att;
    logic             att_en;
    logic [ATT_W-1:0] att_out;
    logic             cur_limit;
    logic [2:0]       step_cnt;
    logic [PRE_W-1:0] latch;
    logic             latch_en;
    logic             park_seq;
    logic             park_active;
    logic             park_done;
    logic             braking;
    logic [7:0]       brake_cnt;
    logic [2:0]       hi;
    logic [2:0]       lo;
    logic             oe;
    logic             sh_track;
    logic             zc_out;
    logic             zc_oe;
    logic             prequal_res;
  } scvc_state_t;

  scvc_state_t r_reg;
  scvc_state_t r_next;

  // ==========================================================================
  // helpers
  // bipolar six-step pattern {hi a,b,c, lo a,b,c}; step 0 is b high, c low
  function automatic logic [5:0] scvc_commut(input logic [2:0] step);
    case (step)
      3'h0:    scvc_commut = 6'b010_001;
      3'h1:    scvc_commut = 6'b100_001;
      3'h2:    scvc_commut = 6'b100_010;
      3'h3:    scvc_commut = 6'b001_010;
      3'h4:    scvc_commut = 6'b001_100;
      3'h5:    scvc_commut = 6'b010_100;
      default: scvc_commut = 6'b000_000;
    endcase
  endfunction

  // high side beats low side on the same phase
  function automatic logic [5:0] scvc_resolve(input logic [5:0] pre);
    scvc_resolve = {pre[5:3], pre[2:0] & ~pre[5:3]};
  endfunction

  function automatic logic [31:0] scvc_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    scvc_merge = (new_v & m) | (old_v & ~m);
  endfunction

  // ==========================================================================
  // next state
  logic        req;
  logic        commit;
  logic        step_rise;
  logic        fall_a;
  logic        tsd;
  logic        all_ones;
  logic        all_zero;
  logic        park_cmd;
  logic [31:0] wv;
  logic [31:0] rd;

  always_comb begin
    r_next = r_reg;

    // two-flop synchronisers, edge detect on the second stage only
    r_next.step_s = {r_reg.step_s[0], i_spindle_step_clock};
    r_next.step_d = r_reg.step_s[1];
    r_next.zc_s1  = {i_zc_phase_c, i_zc_phase_b, i_zc_phase_a};
    r_next.zc_s2  = r_reg.zc_s1;
    r_next.zc_d   = r_reg.zc_s2;
    r_next.mi_s1  = {i_thermal_shutdown, i_thermal_warn, i_sat_detect_cmp,
                     i_cur_limit_cmp, i_prequal_cmp, i_on_delay, i_pwm_in};
    r_next.mi_s2  = r_reg.mi_s1;

    step_rise = r_reg.step_s[1] & ~r_reg.step_d;
    fall_a    = r_reg.zc_d[0] & ~r_reg.zc_s2[0];
    tsd       = r_reg.mi_s2[MI_TSD];
    all_ones  = &r_reg.preload;
    all_zero  = ~|r_reg.preload;

    // ------------------------------------------------------------------------
    // bus slave: one wait cycle, chip select low drops any pending access
    req    = i_avs_chipselect & (i_avs_read | i_avs_write);
    commit = req & ~r_reg.wait_req;
    r_next.wait_req = 1'b1;
    wv = 32'h0;

    rd = 32'h0;
    case (i_avs_address)
      OFF_CTRL:    rd[CTRL_W-1:0] = r_reg.ctrl;
      OFF_PRELOAD: rd[PRE_W-1:0]  = r_reg.preload;
      OFF_DAC: begin
        rd[DAC_W-1:0]               = r_reg.dac;
        rd[ATT_LSB+ATT_W-1:ATT_LSB] = r_reg.att;
        rd[ATT_EN]                  = r_reg.att_en;
      end
      OFF_STATUS: begin
        rd[ST_CURLIM]                = r_reg.cur_limit;
        rd[ST_SATDET]                = r_reg.mi_s2[MI_SAT];
        rd[ST_PREQUAL]               = r_reg.prequal_res;
        rd[ST_PARK]                  = r_reg.park_active;
        rd[ST_PARKDONE]              = r_reg.park_done;
        rd[ST_BRAKE]                 = r_reg.braking;
        rd[ST_STEP_LSB+2:ST_STEP_LSB] = r_reg.step_cnt;
      end
      default:     rd = 32'h0;
    endcase
    rd[ST_TWARN] = r_reg.mi_s2[MI_TWARN];

    if (req && r_reg.wait_req) begin
      r_next.wait_req = 1'b0;
      r_next.rdata    = tsd ? SHUTDOWN_READ : rd;
    end

    if (commit && i_avs_write && !tsd) begin
      case (i_avs_address)
        OFF_CTRL: begin
          wv = scvc_merge(32'(r_reg.ctrl), i_avs_writedata, i_avs_byteenable);
          r_next.ctrl = wv[CTRL_W-1:0];
        end
        OFF_PRELOAD: begin
          wv = scvc_merge(32'(r_reg.preload), i_avs_writedata, i_avs_byteenable);
          r_next.preload = wv[PRE_W-1:0];
        end
        OFF_DAC: begin
          wv = scvc_merge({16'h0, r_reg.att_en, 2'h0, r_reg.att, r_reg.dac},
                          i_avs_writedata, i_avs_byteenable);
          r_next.dac    = wv[DAC_W-1:0];
          r_next.att    = wv[ATT_LSB+ATT_W-1:ATT_LSB];
          r_next.att_en = wv[ATT_EN];
        end
        default: r_next.ctrl = r_reg.ctrl;
      endcase
    end

    // gated here so the attenuator pins leave a flop
    r_next.att_out = r_next.att_en ? r_next.att : 3'h0;

    // ------------------------------------------------------------------------
    // sticky current limit: a status read clears, a new hit wins
    // a read refused in shutdown leaves the flag set
    if (commit && i_avs_read && !tsd && i_avs_address == OFF_STATUS)
      r_next.cur_limit = 1'b0;
    if (r_reg.mi_s2[MI_CURLIM])
      r_next.cur_limit = 1'b1;

    // ------------------------------------------------------------------------
    // phase step counter and commutation latch
    // preload acts on the counter at once; the pattern waits for a step edge
    if (!all_ones) begin
      r_next.step_cnt = 3'h0;
    end else if (step_rise) begin
      r_next.step_cnt = (r_reg.step_cnt == STEP_LAST) ? 3'h0 :
                        r_reg.step_cnt + 3'h1;
    end
    if (step_rise) begin
      r_next.latch    = all_ones ? scvc_commut(r_reg.step_cnt) :
                                   scvc_resolve(r_reg.preload);
      r_next.latch_en = ~all_zero;
    end

    // ------------------------------------------------------------------------
    // brake delay: count falling crossings of phase a, then short windings
    // shutdown parks too; dropping both requests ends the sequence
    park_cmd = r_reg.ctrl[CTRL_PARK] | tsd;
    if (park_cmd && !r_reg.park_seq) begin
      r_next.park_seq    = 1'b1;
      r_next.park_active = 1'b1;
      r_next.park_done   = 1'b0;
      r_next.braking     = 1'b0;
      r_next.brake_cnt   = 8'h00;
    end else if (!park_cmd && r_reg.park_seq) begin
      r_next.park_seq    = 1'b0;
      r_next.park_active = 1'b0;
      r_next.park_done   = 1'b0;
      r_next.braking     = 1'b0;
      r_next.brake_cnt   = 8'h00;
    end else if (r_reg.park_active && fall_a) begin
      if (r_reg.brake_cnt == BRAKE_LAST) begin
        r_next.park_active = 1'b0;
        r_next.park_done   = 1'b1;
        r_next.braking     = 1'b1;
        r_next.brake_cnt   = BRAKE_END;
      end else begin
        r_next.brake_cnt = r_reg.brake_cnt + 8'h01;
      end
    end

    // ------------------------------------------------------------------------
    // driver outputs
    // shutdown overrides braking and tristates every driver
    if (tsd) begin
      r_next.hi = 3'h0;
      r_next.lo = 3'h0;
      r_next.oe = 1'b0;
    end else if (r_reg.braking) begin
      r_next.hi = 3'h0;
      r_next.lo = 3'h7;
      r_next.oe = 1'b1;
    end else begin
      r_next.hi = r_reg.latch[5:PRE_HI];
      r_next.lo = r_reg.latch[PRE_HI-1:0];
      r_next.oe = r_reg.latch_en;
    end

    // ------------------------------------------------------------------------
    // back-emf timing
    r_next.sh_track = r_reg.mi_s2[MI_PWM] & ~r_reg.mi_s2[MI_ONDLY];
    r_next.zc_out   = r_reg.ctrl[CTRL_RUN] ? r_reg.zc_s2[0] :
                                             ^r_reg.zc_s2;
    r_next.zc_oe    = 1'b1;
    r_next.prequal_res = r_reg.mi_s2[MI_PREQ] & r_reg.mi_s2[MI_ONDLY];
  end

  // ==========================================================================
  // registers
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r_reg          <= '0;
      r_reg.wait_req <= 1'b1;
      r_reg.ctrl     <= CTRL_RST;
      r_reg.preload  <= PRE_RST;
      r_reg.dac      <= DAC_RST;
      r_reg.att      <= ATT_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // outputs
  assign o_avs_readdata    = r_reg.rdata;
  assign o_avs_waitrequest = r_reg.wait_req;
  assign o_drive_hi        = r_reg.hi;
  assign o_drive_lo        = r_reg.lo;
  assign o_drive_oe        = r_reg.oe;
  assign o_sample_hold_pin = r_reg.sh_track;
  assign o_zero_cross      = r_reg.zc_out;
  assign o_zero_cross_oe   = r_reg.zc_oe;
  assign o_park            = r_reg.park_active;
  assign o_actuator_dac    = r_reg.dac;
  assign o_atten_sel       = r_reg.att_out;
  assign o_sat_seek        = r_reg.ctrl[CTRL_SATSEEK];
  assign o_sat_polarity    = r_reg.dac[DAC_SIGN];

endmodule // scvc_top

// ---- scvc_pkg.sv ----
// scvc_pkg: register map, field layout and constants of the spindle/actuator control block
package scvc_pkg;

  // ==========================================================================
  // bus geometry
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 32;

  // ==========================================================================
  // register byte offsets
  localparam logic [3:0]  OFF_CTRL      = 4'h0;
  localparam logic [3:0]  OFF_PRELOAD   = 4'h4;
  localparam logic [3:0]  OFF_DAC       = 4'h8;
  localparam logic [3:0]  OFF_STATUS    = 4'hc;

  // ==========================================================================
  // control register fields
  localparam int          CTRL_RUN      = 0;
  localparam int          CTRL_PARK     = 1;
  localparam int          CTRL_SATSEEK  = 2;
  localparam int          CTRL_W        = 3;
  localparam logic [2:0]  CTRL_RST      = 3'h0;

  // ==========================================================================
  // phase preload register: [5:3] high side a,b,c  [2:0] low side a,b,c
  localparam int          PRE_W         = 6;
  localparam int          PRE_HI        = 3;
  localparam logic [5:0]  PRE_RST       = 6'h00;

  // ==========================================================================
  // actuator dac register fields
  localparam int          DAC_W         = 10;
  localparam int          DAC_SIGN      = 9;
  localparam int          ATT_LSB       = 10;
  localparam int          ATT_W         = 3;
  localparam int          ATT_EN        = 15;
  localparam logic [9:0]  DAC_RST       = 10'h000;
  localparam logic [2:0]  ATT_RST       = 3'h0;

  // ==========================================================================
  // status register fields; thermal warning rides in every read
  localparam int          ST_CURLIM     = 0;
  localparam int          ST_SATDET     = 1;
  localparam int          ST_PREQUAL    = 2;
  localparam int          ST_PARK       = 3;
  localparam int          ST_PARKDONE   = 4;
  localparam int          ST_BRAKE      = 5;
  localparam int          ST_STEP_LSB   = 8;
  localparam int          ST_TWARN      = 31;
  localparam logic [31:0] SHUTDOWN_READ = 32'hffffffff;

  // ==========================================================================
  // bit positions of the synchronised misc inputs
  localparam int          MI_PWM        = 0;
  localparam int          MI_ONDLY      = 1;
  localparam int          MI_PREQ       = 2;
  localparam int          MI_CURLIM     = 3;
  localparam int          MI_SAT        = 4;
  localparam int          MI_TWARN      = 5;
  localparam int          MI_TSD        = 6;
  localparam int          MI_W          = 7;

  // ==========================================================================
  // commutation
  localparam logic [2:0]  STEP_LAST     = 3'h5;
  localparam int          BRAKE_COUNT   = 128;

endpackage

// ---- scvc_top_checker.sv ----
// scvc_top_checker: port-level assertions for the spindle/actuator control block
`timescale 1ns/1ps
module scvc_top_checker
  import scvc_pkg::*;
(
  input wire logic                        i_sys_clk,
  input wire logic                        i_resetn,
  input wire logic                        i_avs_chipselect,
  input wire logic                        i_avs_read,
  input wire logic                        i_avs_write,
  input wire logic [scvc_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [scvc_pkg::DATA_W-1:0] o_avs_readdata,
  input wire logic                        o_avs_waitrequest,
  input wire logic                        i_pwm_in,
  input wire logic                        i_on_delay,
  input wire logic                        o_sample_hold_pin,
  input wire logic                        i_thermal_warn,
  input wire logic                        i_thermal_shutdown,
  input wire logic                        o_drive_oe,
  input wire logic                        o_zero_cross_oe,
  input wire logic [9:0]                  o_actuator_dac,
  input wire logic                        o_sat_seek,
  input wire logic                        o_sat_polarity
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // ==========================================================================
  // bus handshake
  sequence s_take;
    i_avs_chipselect && (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence s_read;
    s_take ##0 i_avs_read;
  endsequence
  sequence s_write;
    s_take ##0 i_avs_write;
  endsequence
  a_wait_answer: assert property (s_take |=> !o_avs_waitrequest)
    else $error("request not answered after one cycle");
  a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("answer lasted more than one cycle");
  a_wait_idle: assert property (o_avs_waitrequest && !i_avs_chipselect
    |=> o_avs_waitrequest)
    else $error("answer without a selected request");
  // ==========================================================================
  // thermal behaviour
  a_shut_read: assert property (i_thermal_shutdown[*4] ##0 s_read
    |=> o_avs_readdata == SHUTDOWN_READ)
    else $error("read during shutdown not all ones");
  a_shut_drive: assert property (i_thermal_shutdown[*5] |-> !o_drive_oe)
    else $error("spindle drivers enabled during shutdown");
  a_warn_set: assert property (i_thermal_warn[*4] ##0 s_read |=> o_avs_readdata[ST_TWARN])
    else $error("warning flag missing from read");
  a_warn_clear: assert property ((!i_thermal_warn && !i_thermal_shutdown)[*4] ##0 s_read
    |=> !o_avs_readdata[ST_TWARN])
    else $error("warning flag set without warning");
  // ==========================================================================
  // back-emf, zero-cross pin, seek and dac in shutdown
  a_sh_track: assert property ((i_pwm_in && !i_on_delay)[*5] |-> o_sample_hold_pin)
    else $error("sample/hold not tracking in on-time");
  a_sh_off: assert property ((!i_pwm_in)[*5] |-> !o_sample_hold_pin)
    else $error("sample/hold not holding in off-time");
  a_sh_delay: assert property (i_on_delay[*5] |-> !o_sample_hold_pin)
    else $error("sample/hold not holding in on-delay");
  a_zc_float: assert property (disable iff (1'b0) !i_resetn |-> !o_zero_cross_oe)
    else $error("zero-cross pin driven during reset");
  a_seek_sign: assert property (o_sat_seek |-> o_sat_polarity == o_actuator_dac[DAC_SIGN])
    else $error("seek polarity differs from dac sign");
  a_shut_dac: assert property (i_thermal_shutdown[*4] ##0 s_write
    |=> ##1 $stable(o_actuator_dac))
    else $error("dac written during shutdown");
endmodule // scvc_top_checker

bind scvc_top scvc_top_checker scvc_top_checker_inst (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_avs_chipselect(i_avs_chipselect),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_pwm_in(i_pwm_in), .i_on_delay(i_on_delay), .i_thermal_warn(i_thermal_warn),
  .i_thermal_shutdown(i_thermal_shutdown), .o_drive_oe(o_drive_oe),
  .o_zero_cross_oe(o_zero_cross_oe), .o_actuator_dac(o_actuator_dac),
  .o_sat_seek(o_sat_seek), .o_sat_polarity(o_sat_polarity),
  .o_sample_hold_pin(o_sample_hold_pin)
);

// ---- scvc_motor_model.sv ----
// scvc_motor_model: motor controller side, step clock and zero-cross comparators
`timescale 1ns/1ps
module scvc_motor_model (
  output logic o_step,
  output logic o_zc_a,
  output logic o_zc_b,
  output logic o_zc_c
);
  initial begin
    o_step = 1'b0;
    {o_zc_a, o_zc_b, o_zc_c} = 3'h0;
  end
  // step pulses, 64 ns period, idle low between bursts
  task automatic step(input int n);
    #3;
    repeat (n) begin
      o_step = 1'b1;
      #32;
      o_step = 1'b0;
      #32;
    end
  endtask
  // falling crossings of phase a
  task automatic fall_a(input int n);
    #3;
    repeat (n) begin
      o_zc_a = 1'b1;
      #32;
      o_zc_a = 1'b0;
      #32;
    end
  endtask
  task automatic set_zc(input logic a, input logic b, input logic c);
    #3;
    {o_zc_a, o_zc_b, o_zc_c} = {a, b, c};
  endtask
endmodule // scvc_motor_model

// ---- scvc_top_tb_top.sv ----
// scvc_top_tb_top: self-checking bench for the spindle/actuator control block
`timescale 1ns/1ps
module scvc_top_tb_top;
  import scvc_pkg::*;
  logic        i_sys_clk, i_resetn, cs, rd, wr, stp, za, zb, zc, pwm, ond, preq, clim;
  logic        sat, twarn, tsd, wreq, doe, sh, zx, zxoe, park, seek, pol;
  logic [3:0]  ad, be;
  logic [31:0] wd, rdat, q;
  logic [2:0]  hi, lo, att, ph;
  logic [9:0]  dac;
  int          errors = 0, compares = 0, cycles = 0;
  // preload, expected high side, low side, enable
  logic [12:0] rows [7] = '{{6'h07, 3'h0, 3'h7, 1'b1}, {6'h2d, 3'h5, 3'h0, 1'b1},
    {6'h15, 3'h2, 3'h5, 1'b1}, {6'h12, 3'h2, 3'h0, 1'b1}, {6'h00, 3'h0, 3'h0, 1'b0},
    {6'h28, 3'h5, 3'h0, 1'b1}, {6'h38, 3'h7, 3'h0, 1'b1}};
  logic [2:0]  seq_hi [6] = '{3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};
  logic [2:0]  seq_lo [6] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};

  scvc_top #(.BRAKE_CROSSINGS(4)) scvc_top_inst (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_avs_address(ad), .i_avs_chipselect(cs),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_spindle_step_clock(stp),
    .i_zc_phase_a(za), .i_zc_phase_b(zb), .i_zc_phase_c(zc), .i_pwm_in(pwm),
    .i_on_delay(ond), .i_prequal_cmp(preq), .i_cur_limit_cmp(clim), .i_sat_detect_cmp(sat),
    .i_thermal_warn(twarn), .i_thermal_shutdown(tsd), .o_drive_hi(hi), .o_drive_lo(lo),
    .o_drive_oe(doe), .o_sample_hold_pin(sh), .o_zero_cross(zx), .o_zero_cross_oe(zxoe),
    .o_park(park), .o_actuator_dac(dac), .o_atten_sel(att), .o_sat_seek(seek),
    .o_sat_polarity(pol));
  scvc_motor_model scvc_motor_model_inst (.o_step(stp), .o_zc_a(za), .o_zc_b(zb), .o_zc_c(zc));

  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end
  // ==========================================================================
  // tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    cs <= 1'b1;
    rd <= !w;
    wr <= w;
    ad <= a;
    wd <= d;
    do @(posedge i_sys_clk); while (wreq !== 1'b0);
    r = rdat;
    cs <= 1'b0;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    {i_resetn, cs, rd, wr, pwm, ond, preq, clim, sat, twarn, tsd} = 11'h000;
    ad = 4'h0;
    be = 4'hf;
    wd = 32'h0;
    ph = 3'h0;
    cyc(20);
    chk("rst_wait", 32'h1, 32'(wreq));
    chk("rst_zc_oe", 32'h0, 32'(zxoe));
    i_resetn <= 1'b1;
    cyc(2);
    chk("run_zc_oe", 32'h1, 32'(zxoe));
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, OFF_PRELOAD, 32'(rows[i][12:7]), q);
      cyc(6);
      chk("hold_hi", 32'(ph), 32'(hi));
      scvc_motor_model_inst.step(1);
      cyc(6);
      chk("drive_hi", 32'(rows[i][6:4]), 32'(hi));
      chk("drive_lo", 32'(rows[i][3:1]), 32'(lo));
      chk("drive_oe", 32'(rows[i][0]), 32'(doe));
      ph = rows[i][6:4];
    end
    tsd <= 1'b1;
    cyc(5);
    bus(1'b0, OFF_CTRL, 32'h0, q);
    chk("shut_read", SHUTDOWN_READ, q);
    bus(1'b1, OFF_PRELOAD, 32'h07, q);
    chk("shut_oe", 32'h0, 32'(doe));
    bus(1'b1, OFF_DAC, 32'h000003ff, q);
    chk("shut_dac", 32'h0, 32'(dac));
    tsd <= 1'b0;
    cyc(5);
    scvc_motor_model_inst.step(1);
    cyc(6);
    chk("kept_hi", 32'h7, 32'(hi));
    bus(1'b1, OFF_PRELOAD, 32'h3f, q);
    for (int k = 0; k < 7; k++) begin
      scvc_motor_model_inst.step(1);
      cyc(6);
      chk("seq_hi", 32'(seq_hi[k % 6]), 32'(hi));
      chk("seq_lo", 32'(seq_lo[k % 6]), 32'(lo));
      bus(1'b0, OFF_STATUS, 32'h0, q);
      chk("step_cnt", 32'((k + 1) % 6), 32'(q[10:8]));
    end
    bus(1'b1, OFF_PRELOAD, 32'h2d, q);
    bus(1'b0, OFF_STATUS, 32'h0, q);
    chk("step_held", 32'h0, 32'(q[10:8]));
    bus(1'b1, OFF_CTRL, 32'h2, q);
    cyc(4);
    chk("park_on", 32'h1, 32'(park));
    scvc_motor_model_inst.fall_a(3);
    cyc(5);
    chk("park_wait", 32'h1, 32'(park));
    scvc_motor_model_inst.fall_a(1);
    cyc(5);
    chk("park_end", 32'h0, 32'(park));
    chk("brake_pat", 32'h07, 32'({hi, lo}));
    bus(1'b0, OFF_STATUS, 32'h0, q);
    chk("brake_st", 32'h6, 32'(q[5:3]));
    bus(1'b1, OFF_CTRL, 32'h0, q);
    cyc(3);
    bus(1'b0, OFF_STATUS, 32'h0, q);
    chk("brake_clr", 32'h0, 32'(q[5:3]));
    bus(1'b1, OFF_CTRL, 32'h2, q);
    scvc_motor_model_inst.fall_a(3);
    cyc(5);
    chk("park_again", 32'h1, 32'(park));
    bus(1'b1, OFF_CTRL, 32'h0, q);
    wr <= 1'b1;
    ad <= OFF_PRELOAD;
    wd <= 32'h0;
    cyc(4);
    chk("no_cs", 32'h1, 32'(wreq));
    wr <= 1'b0;
    scvc_motor_model_inst.step(1);
    cyc(6);
    chk("no_cs_oe", 32'h1, 32'(doe));
    {clim, sat, preq, ond, twarn} <= 5'h1f;
    cyc(2);
    clim <= 1'b0;
    cyc(4);
    bus(1'b0, OFF_STATUS, 32'h0, q);
    chk("status_a", 32'h80000007, q & 32'h80000007);
    bus(1'b0, OFF_STATUS, 32'h0, q);
    chk("status_b", 32'h80000006, q & 32'h80000007);
    bus(1'b0, 4'h2, 32'h0, q);
    chk("unmapped", 32'h80000000, q);
    {ond, twarn} <= 2'h0;
    cyc(5);
    bus(1'b0, OFF_STATUS, 32'h0, q);
    chk("status_c", 32'h2, q & 32'h80000007);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, OFF_DAC, {16'h0, 1'b1, 2'h0, 3'(i), 10'h2a5}, q);
      cyc(1);
      chk("atten", 32'(i), 32'(att));
    end
    chk("dac", 32'h2a5, 32'(dac));
    bus(1'b1, OFF_DAC, {16'h0, 1'b0, 2'h0, 3'h7, 10'h2a5}, q);
    cyc(1);
    chk("full_gain", 32'h0, 32'(att));
    be <= 4'h1;
    bus(1'b1, OFF_DAC, 32'h0000ff5a, q);
    be <= 4'hf;
    chk("byte_lane", 32'h025a, 32'({att, dac}));
    bus(1'b1, OFF_CTRL, 32'h4, q);
    cyc(1);
    chk("seek", 32'h3, 32'({seek, pol}));
    scvc_motor_model_inst.set_zc(1'b0, 1'b1, 1'b0);
    cyc(5);
    chk("zc_start", 32'h1, 32'(zx));
    bus(1'b1, OFF_CTRL, 32'h1, q);
    scvc_motor_model_inst.set_zc(1'b1, 1'b1, 1'b0);
    cyc(5);
    chk("zc_run", 32'h1, 32'(zx));
    for (int i = 0; i < 4; i++) begin
      pwm <= i[0];
      ond <= i[1];
      cyc(5);
      chk("sample_hold", 32'(i == 1), 32'(sh));
    end
    wrap_up();
  end
endmodule // scvc_top_tb_top
